// file: hw/hpir_regs.sv
// Hybrid balance, power override and first interrupt pending register bank
// How it works
// - Pulse meter gain in bits 6:4; 111 off
// - Audio gain in bits 2:0; 111 off
// - Bit 5 forces meter DAC on
// - Bit 4 forces converter off; fixed 1 without converter
// - Bit 3 forces monitor ADC off
// - Bit 1 forces dc bias off
// - Bit 0 forces line interface off
// - ADC manual select gates ADC on bit
// - DAC manual select gates DAC on bit
// - Transamp manual select gates its on bit
// - Pending flags ordered meter, ring, tones
// - Pending reads 1; write 1 clears
// - Enable register masks each event from irq
`timescale 1ns/1ps
`include "hpir_consts.svh"
module hpir_regs #(
   parameter bit HAS_CONVERTER = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register access from serial port
   input wire hpir_pkg::hpir_req_type req,
   output logic [7:0] rdata,
   // Timer events, one-cycle pulses, bit order as pending register
   input wire logic [7:0] event_in,
   // Steering outputs
   output hpir_pkg::hpir_hyb_type hyb,
   output hpir_pkg::hpir_pwr_type pwr,
   output logic irq_b
);
   import hpir_pkg::*;

   // Register state
   logic [7:0] hybrid_balance_control_r; // Gain selectors
   logic [7:0] power_override_control_r; // Force overrides
   logic [7:0] converter_power_control_r; // Manual power select
   logic [7:0] timer_irq_pending_r; // Sticky flags
   logic [7:0] timer_irq_enable_r; // Event mask
   logic [7:0] pend_nxt;
   logic [7:0] conv_fix;

   // Write strobe decode shared by all registers
   function automatic logic wr_hit(input hpir_req_type r, input logic [7:0] ofs);
      wr_hit = r.wr && (r.addr == ofs);
   endfunction

   // Converter bit pinned high on variants without the converter
   assign conv_fix = HAS_CONVERTER ? 8'h00 : (8'h01 << `HPIR_BIT_CONV_OFF);

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   // Hybrid gain register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hybrid_balance_control_r <= `HPIR_RST_HYBRID;
      end else if (wr_hit(req, `HPIR_OFS_HYBRID)) begin
         hybrid_balance_control_r <= req.wdata & `HPIR_MASK_HYBRID;
      end
   end

   // Power override register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         power_override_control_r <= `HPIR_RST_PWR1;
      end else if (wr_hit(req, `HPIR_OFS_PWR1)) begin
         power_override_control_r <= (req.wdata & `HPIR_MASK_PWR1) | conv_fix;
      end
   end

   // Manual power register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         converter_power_control_r <= `HPIR_RST_PWR2;
      end else if (wr_hit(req, `HPIR_OFS_PWR2)) begin
         converter_power_control_r <= req.wdata & `HPIR_MASK_PWR2;
      end
   end

   // Interrupt enable register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         timer_irq_enable_r <= `HPIR_RST_IRQEN;
      end else if (wr_hit(req, `HPIR_OFS_IRQEN)) begin
         timer_irq_enable_r <= req.wdata;
      end
   end

   // ------------------------------------------------------------
   // Pending flags
   // ------------------------------------------------------------
   // Set beats clear so an event in the clearing cycle survives
   always_comb begin
      pend_nxt = timer_irq_pending_r;
      if (wr_hit(req, `HPIR_OFS_PEND)) begin
         pend_nxt = pend_nxt & ~req.wdata;
      end
      pend_nxt = pend_nxt | event_in;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         timer_irq_pending_r <= `HPIR_RST_PEND;
      end else begin
         timer_irq_pending_r <= pend_nxt;
      end
   end

   assign irq_b = ~|(timer_irq_pending_r & timer_irq_enable_r);

   // ------------------------------------------------------------
   // Readback and steering
   // ------------------------------------------------------------
   // Read mux, unmapped reads give zero
   always_comb begin
      unique case (req.addr)
         `HPIR_OFS_HYBRID: rdata = hybrid_balance_control_r;
         `HPIR_OFS_PWR1: rdata = power_override_control_r;
         `HPIR_OFS_PWR2: rdata = converter_power_control_r;
         `HPIR_OFS_PEND: rdata = timer_irq_pending_r;
         `HPIR_OFS_IRQEN: rdata = timer_irq_enable_r;
         default: rdata = 8'h00;
      endcase
   end

   assign hyb.pulse_meter_balance_gain = hybrid_balance_control_r[6:4];
   assign hyb.pulse_meter_hybrid_off = hybrid_balance_control_r[6:4] == `HPIR_GAIN_OFF;
   assign hyb.audio_balance_gain = hybrid_balance_control_r[2:0];
   assign hyb.audio_hybrid_off = hybrid_balance_control_r[2:0] == `HPIR_GAIN_OFF;
   assign pwr.meter_dac_force_on = power_override_control_r[5];
   assign pwr.converter_force_off = power_override_control_r[4];
   assign pwr.monitor_adc_force_off = power_override_control_r[3];
   assign pwr.dc_bias_force_off = power_override_control_r[1];
   assign pwr.line_iface_force_off = power_override_control_r[0];
   assign pwr.adc_manual = converter_power_control_r[5];
   assign pwr.adc_on = converter_power_control_r[5] & converter_power_control_r[4];
   assign pwr.dac_manual = converter_power_control_r[3];
   assign pwr.dac_on = converter_power_control_r[3] & converter_power_control_r[2];
   assign pwr.transamp_manual = converter_power_control_r[1];
   assign pwr.transamp_on = converter_power_control_r[1] & converter_power_control_r[0];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Clearing write on flag 0 with no event racing it
   sequence clear_write_s;
      wr_hit(req, `HPIR_OFS_PEND) && req.wdata[0] && !event_in[0];
   endsequence

   // Pending flag checks
   pend_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
      clear_write_s |=> !timer_irq_pending_r[0])
      else $error("pending flag not cleared by write one");
   set_wins_a: assert property (@(posedge clk) disable iff (!rst_b)
      event_in[7] |=> timer_irq_pending_r[7])
      else $error("event lost");
   write_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
      wr_hit(req, `HPIR_OFS_PEND) && !req.wdata[3] && timer_irq_pending_r[3]
      |=> timer_irq_pending_r[3])
      else $error("write zero changed flag");
   // Interrupt output checks, judged from enable writes and event inputs, not the output expression
   irq_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
      wr_hit(req, `HPIR_OFS_IRQEN) && req.wdata == 8'h00 |=> irq_b)
      else $error("masked event raised interrupt");
   irq_raise_a: assert property (@(posedge clk) disable iff (!rst_b)
      (event_in & timer_irq_enable_r) != 8'h00 && !wr_hit(req, `HPIR_OFS_IRQEN)
      |=> !irq_b)
      else $error("enabled event did not raise interrupt");
   // Field and override checks
   reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
      hybrid_balance_control_r[7] == 1'b0 && hybrid_balance_control_r[3] == 1'b0
      && power_override_control_r[2] == 1'b0)
      else $error("reserved bit set");
   reserved_pwr_a: assert property (@(posedge clk) disable iff (!rst_b)
      power_override_control_r[7:6] == 2'b00 && converter_power_control_r[7:6] == 2'b00)
      else $error("reserved power bit set");
   conv_fixed_a: assert property (@(posedge clk) disable iff (!rst_b)
      !HAS_CONVERTER |-> pwr.converter_force_off)
      else $error("converter bit not fixed high");
   adc_manual_a: assert property (@(posedge clk) disable iff (!rst_b)
      !pwr.adc_manual |-> !pwr.adc_on)
      else $error("adc on outside manual mode");
   dac_manual_a: assert property (@(posedge clk) disable iff (!rst_b)
      !pwr.dac_manual |-> !pwr.dac_on)
      else $error("dac on outside manual mode");
   amp_manual_a: assert property (@(posedge clk) disable iff (!rst_b)
      !pwr.transamp_manual |-> !pwr.transamp_on)
      else $error("amp on outside manual mode");
   meter_write_a: assert property (@(posedge clk) disable iff (!rst_b)
      wr_hit(req, `HPIR_OFS_HYBRID) |=> hyb.pulse_meter_balance_gain == $past(req.wdata[6:4]))
      else $error("meter gain not written");
   audio_off_a: assert property (@(posedge clk) disable iff (!rst_b)
      wr_hit(req, `HPIR_OFS_HYBRID)
      |=> hyb.audio_hybrid_off == ($past(req.wdata[2:0]) == 3'h7))
      else $error("audio off decode wrong");
   force_a: assert property (@(posedge clk) disable iff (!rst_b)
      wr_hit(req, `HPIR_OFS_PWR1) |=> pwr.meter_dac_force_on == $past(req.wdata[5])
      && pwr.monitor_adc_force_off == $past(req.wdata[3])
      && pwr.dc_bias_force_off == $past(req.wdata[1])
      && pwr.line_iface_force_off == $past(req.wdata[0]))
      else $error("override bits not written");
endmodule

// file: hw/hpir_consts.svh
// Register offsets, field positions, reset values of the hybrid/power/irq bank
`ifndef HPIR_CONSTS_SVH
`define HPIR_CONSTS_SVH
`define HPIR_OFS_HYBRID 8'h0b
`define HPIR_OFS_PWR1 8'h0e
`define HPIR_OFS_PWR2 8'h0f
`define HPIR_OFS_PEND 8'h12
`define HPIR_OFS_IRQEN 8'h15
`define HPIR_RST_HYBRID 8'h33
`define HPIR_RST_PWR1 8'h10
`define HPIR_RST_PWR2 8'h00
`define HPIR_RST_PEND 8'h00
`define HPIR_RST_IRQEN 8'h00
`define HPIR_MASK_HYBRID 8'h77
`define HPIR_MASK_PWR1 8'h3b
`define HPIR_MASK_PWR2 8'h3f
`define HPIR_BIT_CONV_OFF 4
`define HPIR_GAIN_OFF 3'h7
`endif

// file: hw/hpir_pkg.sv
// Types shared by the hybrid/power/irq register bank
package hpir_pkg;
   // Register access request from the serial port decoder
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hpir_req_type;
   // Power steering outputs
   typedef struct packed {
      logic meter_dac_force_on;
      logic converter_force_off;
      logic monitor_adc_force_off;
      logic dc_bias_force_off;
      logic line_iface_force_off;
      logic adc_manual;
      logic adc_on;
      logic dac_manual;
      logic dac_on;
      logic transamp_manual;
      logic transamp_on;
   } hpir_pwr_type;
   // Hybrid balance outputs
   typedef struct packed {
      logic [2:0] pulse_meter_balance_gain;
      logic pulse_meter_hybrid_off;
      logic [2:0] audio_balance_gain;
      logic audio_hybrid_off;
   } hpir_hyb_type;
endpackage

// file: bench/hpir_host.sv
// Host model issuing register requests to the bank
`timescale 1ns/1ps
module hpir_host (
   // Clock
   input wire logic clk,
   // Register request port
   output hpir_pkg::hpir_req_type req,
   input wire logic [7:0] rdata
);
   import hpir_pkg::*;
   // Idle at time zero, no strobe
   initial req = '0;
   // Write held one cycle, taken on the next edge
   // host clears a flag by writing one
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge clk);
      req.wr <= 1'b0;
      // Released data shows no stale value
      req.wdata <= ~d;
      // Return off the edge so callers see the written state settled
      @(negedge clk);
   endtask
   // Read: address held, data taken at next edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge clk);
      d = rdata;
      req.rd <= 1'b0;
   endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the hybrid/power/irq register bank
`timescale 1ns/1ps
`include "hpir_consts.svh"
module testbench;
   import hpir_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] event_in = 8'h00;
   logic irq_b;
   logic [7:0] rdata;
   hpir_req_type req;
   hpir_hyb_type hyb;
   hpir_pwr_type pwr;
   int failures = 0;
   int tests_run = 0;
   // Clock at 8 ns period
   initial forever #4 clk = ~clk;
   hpir_regs hpir_regs_inst (.clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata),
      .event_in(event_in), .hyb(hyb), .pwr(pwr), .irq_b(irq_b));
   hpir_host hpir_host_inst (.clk(clk), .req(req), .rdata(rdata));
   // Compare and count
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Read a register and compare
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      hpir_host_inst.rd(a, d);
      chk("rdata", {8'h00, e}, {8'h00, d});
   endtask
   // One-cycle event pulse
   task automatic pulse(input logic [7:0] v);
      @(posedge clk);
      event_in <= v;
      @(posedge clk);
      event_in <= 8'h00;
   endtask
   // Reset values
   task automatic t_reset();
      rchk(`HPIR_OFS_HYBRID, 8'h33);
      rchk(`HPIR_OFS_PWR1, 8'h10);
      rchk(`HPIR_OFS_PWR2, 8'h00);
      rchk(`HPIR_OFS_PEND, 8'h00);
      rchk(`HPIR_OFS_IRQEN, 8'h00);
      chk("irq_b", 16'h1, {15'h0, irq_b});
   endtask
   // Gains, off codes, reserved bits
   task automatic t_hybrid();
      hpir_host_inst.wr(`HPIR_OFS_HYBRID, 8'hff);
      rchk(`HPIR_OFS_HYBRID, 8'h77);
      chk("hyb", 16'hff, {8'h00, hyb});
      hpir_host_inst.wr(`HPIR_OFS_HYBRID, 8'h25);
      chk("hyb", 16'h4a, {8'h00, hyb});
   endtask
   // Overrides and manual power gating
   task automatic t_power();
      hpir_host_inst.wr(`HPIR_OFS_PWR1, 8'hff);
      hpir_host_inst.wr(`HPIR_OFS_PWR2, 8'h15);
      rchk(`HPIR_OFS_PWR1, 8'h3b);
      chk("pwr", 16'h7c0, {5'h00, pwr});
      hpir_host_inst.wr(`HPIR_OFS_PWR1, 8'h00);
      hpir_host_inst.wr(`HPIR_OFS_PWR2, 8'hff);
      rchk(`HPIR_OFS_PWR2, 8'h3f);
      chk("pwr", 16'h03f, {5'h00, pwr});
      rchk(8'h40, 8'h00);
   endtask
   // Pending set, mask, write-one clear, set beats clear
   task automatic t_pending();
      pulse(8'h81);
      rchk(`HPIR_OFS_PEND, 8'h81);
      chk("irq_b", 16'h1, {15'h0, irq_b});
      hpir_host_inst.wr(`HPIR_OFS_IRQEN, 8'h01);
      chk("irq_b", 16'h0, {15'h0, irq_b});
      hpir_host_inst.wr(`HPIR_OFS_PEND, 8'h80);
      rchk(`HPIR_OFS_PEND, 8'h01);
      hpir_host_inst.wr(`HPIR_OFS_PEND, 8'h00);
      rchk(`HPIR_OFS_PEND, 8'h01);
      fork
         hpir_host_inst.wr(`HPIR_OFS_PEND, 8'h01);
         pulse(8'h01);
      join
      rchk(`HPIR_OFS_PEND, 8'h01);
      hpir_host_inst.wr(`HPIR_OFS_PEND, 8'h01);
      chk("irq_b", 16'h1, {15'h0, irq_b});
      // Middle flags land in their own positions
      pulse(8'h7e);
      rchk(`HPIR_OFS_PEND, 8'h7e);
      chk("irq_b", 16'h1, {15'h0, irq_b});
      hpir_host_inst.wr(`HPIR_OFS_IRQEN, 8'h02);
      chk("irq_b", 16'h0, {15'h0, irq_b});
      hpir_host_inst.wr(`HPIR_OFS_IRQEN, 8'h00);
      chk("irq_b", 16'h1, {15'h0, irq_b});
      hpir_host_inst.wr(`HPIR_OFS_PEND, 8'hff);
      rchk(`HPIR_OFS_PEND, 8'h00);
   endtask
   // Single place that ends the run
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Main sequence after ten reset cycles
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_hybrid();
      t_power();
      t_pending();
      give_verdict();
   end
   // Watchdog cuts a hang short
   initial begin
      #(2000 * 8);
      failures++;
      give_verdict();
   end
endmodule
